// *** pkg/psl_pkg.sv ***
package psl_pkg;

    // register byte offsets
    localparam logic [11:0] ctrl_offset = 12'h000;
    localparam logic [11:0] lamp_offset = 12'h004;
    localparam logic [11:0] status_offset = 12'h008;
    localparam logic [11:0] mask_offset = 12'h00c;
    localparam logic [11:0] cond_offset = 12'h010;

    // ctrl register field positions
    localparam int ctrl_video_en_bit = 0;
    localparam int ctrl_page_done_bit = 1;
    localparam int ctrl_cmd_go_bit = 2;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [31:0] mask_reset = 32'h0000_0000;

    // status register event bits
    localparam int ev_jam_bit = 0;
    localparam int ev_error_bit = 1;
    localparam int ev_paper_bit = 2;
    localparam int ev_stop_bit = 3;
    localparam int ev_resp_bit = 4;
    localparam int ev_width = 5;

    // flash timing: half period of the lamp flash
    localparam int flash_half_ms = 250;
    localparam int clk_khz = 50000;
    localparam int flash_half_cycles = flash_half_ms * clk_khz;
    localparam int div_width = 24;

    // synchroniser depth for outside inputs
    localparam int sync_depth = 3;

    // lamp drive states
    typedef enum logic [1:0]
    {
        psl_lamp_off_type_v = 2'b00,
        psl_lamp_on_type_v = 2'b01,
        psl_lamp_flash_type_v = 2'b10
    } psl_lamp_mode_type;

    // printer conditions as seen from the pins
    typedef struct packed
    {
        logic warmup;
        logic ready;
        logic operating;
        logic error;
        logic cover_open;
        logic toner_low;
        logic cart_bad;
        logic paper_out;
        logic tray_missing;
        logic manual_ready;
        logic paper_jam;
    } psl_cond_type;

    localparam int cond_width = 11;

    // four lamp drive outputs
    typedef struct packed
    {
        logic ready_green;
        logic toner_orange;
        logic paper_red;
        logic jam_red;
    } psl_lamps_type;

    // video streaming states
    typedef enum logic [1:0]
    {
        psl_vid_idle_type_v = 2'b00,
        psl_vid_send_type_v = 2'b01,
        psl_vid_stop_type_v = 2'b10
    } psl_vid_state_type;

endpackage

// *** rtl/psl_sync.sv ***
`timescale 1ns/1ps
module psl_sync
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw and settled conditions
    input wire logic [psl_pkg::cond_width-1:0] raw,
    output logic [psl_pkg::cond_width-1:0] clean
);

    logic [psl_pkg::cond_width-1:0] st1;
    logic [psl_pkg::cond_width-1:0] st2;
    logic [psl_pkg::cond_width-1:0] st3;
    logic [psl_pkg::cond_width-1:0] next_clean;

    // accept a change only when stages two and three agree
    always_comb
    begin
        for (int i = 0; i < psl_pkg::cond_width; i++)
        begin
            next_clean[i] = (st2[i] == st3[i]) ? st2[i] : clean[i];
        end
    end

    // three stage chain, first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st1 <= '0;
            st2 <= '0;
            st3 <= '0;
            clean <= '0;
        end
        else
        begin
            st1 <= raw;
            st2 <= st1;
            st3 <= st2;
            clean <= next_clean;
        end
    end

endmodule

// *** rtl/psl_flash_div.sv ***
`timescale 1ns/1ps
module psl_flash_div
#(
    parameter int half_cycles = psl_pkg::flash_half_cycles
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // shared flash phase and its toggle pulse
    output logic phase,
    output logic tick
);

    logic [psl_pkg::div_width-1:0] count;
    logic [psl_pkg::div_width-1:0] next_count;
    logic next_phase;
    logic wrap;

    // one counter for every lamp keeps flashing lamps in phase
    always_comb
    begin
        wrap = (count == psl_pkg::div_width'(half_cycles - 1));
        next_count = wrap ? '0 : count + 1'b1;
        next_phase = wrap ? ~phase : phase; // R12
    end

    assign tick = wrap;

    // divider state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            phase <= 1'b0;
        end
        else
        begin
            count <= next_count;
            phase <= next_phase;
        end
    end

endmodule

// *** rtl/psl_status_lamps.sv ***
`timescale 1ns/1ps
// What this block does
// (R1) green lamp flashes during warmup and while operating.
// (R2) green lamp steady when warmed up and ready.
// (R3) green lamp off on error or cover open, or if not ready and neither warming up nor operating.
// (R4) orange lamp steady while toner needs replacement.
// (R5) orange lamp flashes on bad cartridge install, else off.
// (R6) red paper lamp steady on no paper or missing tray.
// (R7) red paper lamp flashes while manual feed is ready.
// (R8) jam lamp lights on a jam and latches until cleared.
// (R9) on any error both red lamps flash together.
// (R10) video bits flow until page done or paper-out, jam, error.
// (R11) send parameter commands to engine and watch returned status.
// (R12) all flashing lamps share one divider so they stay in phase.
// (R13) joint error flash overrides the paper and jam lamp states.
module psl_status_lamps
#(
    parameter int flash_half_cycles = psl_pkg::flash_half_cycles
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // printer conditions from pins
    input wire psl_pkg::psl_cond_type cond_in,
    // front panel lamps
    output psl_pkg::psl_lamps_type lamps,
    // video to engine_controller
    input wire logic video_bit,
    output logic video_out,
    output logic video_active,
    // command and status with engine_controller
    output logic [7:0] cmd_data,
    output logic cmd_valid,
    input wire logic [7:0] engine_status,
    input wire logic engine_status_valid,
    // interrupt
    output logic irq
);

    psl_pkg::psl_cond_type cond;
    logic [psl_pkg::cond_width-1:0] cond_clean;
    logic flash_phase;
    logic status_strobe_s1;
    logic status_strobe_s2;
    logic status_strobe_s3;
    logic [7:0] status_s1;
    logic [7:0] status_s2;
    logic [7:0] engine_stat;
    logic [7:0] next_engine_stat;

    // settle the printer conditions
    psl_sync u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .raw(cond_in),
        .clean(cond_clean)
    );

    assign cond = cond_clean;

    // shared flash source
    psl_flash_div #(.half_cycles(flash_half_cycles)) u_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .phase(flash_phase),
        .tick()
    );

    // lamp mode to drive level
    function automatic logic lamp_drive(input psl_pkg::psl_lamp_mode_type m, input logic ph);
        case (m)
            psl_pkg::psl_lamp_on_type_v: lamp_drive = 1'b1;
            psl_pkg::psl_lamp_flash_type_v: lamp_drive = ph;
            default: lamp_drive = 1'b0;
        endcase
    endfunction

    // ---- lamp state
    logic jam_latch;
    logic next_jam_latch;
    psl_pkg::psl_lamp_mode_type mode_green;
    psl_pkg::psl_lamp_mode_type mode_toner;
    psl_pkg::psl_lamp_mode_type mode_paper;
    psl_pkg::psl_lamp_mode_type mode_jam;
    psl_pkg::psl_lamps_type next_lamps;

    // lamp decisions; error outranks the individual red states
    always_comb
    begin
        // jam stays lit until the jam input reports cleared
        next_jam_latch = cond.paper_jam ? 1'b1 : (jam_latch & cond.paper_jam); // R8
        if (cond.error || cond.cover_open)
        begin
            mode_green = psl_pkg::psl_lamp_off_type_v; // R3
        end
        else if (cond.warmup || cond.operating)
        begin
            mode_green = psl_pkg::psl_lamp_flash_type_v; // R1
        end
        else if (cond.ready)
        begin
            mode_green = psl_pkg::psl_lamp_on_type_v; // R2
        end
        else
        begin
            mode_green = psl_pkg::psl_lamp_off_type_v; // R3
        end
        // replacement wins over misinstall when both are reported
        if (cond.toner_low)
        begin
            mode_toner = psl_pkg::psl_lamp_on_type_v; // R4
        end
        else if (cond.cart_bad)
        begin
            mode_toner = psl_pkg::psl_lamp_flash_type_v; // R5
        end
        else
        begin
            mode_toner = psl_pkg::psl_lamp_off_type_v; // R5
        end
        if (cond.error)
        begin
            mode_paper = psl_pkg::psl_lamp_flash_type_v; // R9 R13
            mode_jam = psl_pkg::psl_lamp_flash_type_v; // R9 R13
        end
        else
        begin
            if (cond.paper_out || cond.tray_missing)
            begin
                mode_paper = psl_pkg::psl_lamp_on_type_v; // R6
            end
            else if (cond.manual_ready)
            begin
                mode_paper = psl_pkg::psl_lamp_flash_type_v; // R7
            end
            else
            begin
                mode_paper = psl_pkg::psl_lamp_off_type_v;
            end
            mode_jam = jam_latch ? psl_pkg::psl_lamp_on_type_v : psl_pkg::psl_lamp_off_type_v; // R8
        end
        // one phase for all so joint flashing is in step
        next_lamps.ready_green = lamp_drive(mode_green, flash_phase); // R12
        next_lamps.toner_orange = lamp_drive(mode_toner, flash_phase); // R12
        next_lamps.paper_red = lamp_drive(mode_paper, flash_phase); // R12
        next_lamps.jam_red = lamp_drive(mode_jam, flash_phase); // R12
    end

    // lamp registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jam_latch <= 1'b0;
            lamps <= '0;
        end
        else
        begin
            jam_latch <= next_jam_latch;
            lamps <= next_lamps;
        end
    end

    // ---- register file
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [psl_pkg::ev_width-1:0] status;
    logic [psl_pkg::ev_width-1:0] next_status;
    logic [psl_pkg::ev_width-1:0] mask;
    logic [psl_pkg::ev_width-1:0] next_mask;
    logic [psl_pkg::ev_width-1:0] events;
    logic [31:0] prdata_comb;
    logic next_cmd_valid;
    logic [7:0] next_cmd_data;
    logic wr_en;
    logic addr_ok;

    // ---- video streaming
    psl_pkg::psl_vid_state_type vid_state;
    psl_pkg::psl_vid_state_type next_vid_state;
    logic stop_cause;
    logic next_video_out;
    logic prev_jam;
    logic prev_err;
    logic prev_paper;

    assign stop_cause = cond.paper_out | cond.paper_jam | cond.error;
    assign wr_en = psel & penable & pwrite;
    assign addr_ok = (paddr == psl_pkg::ctrl_offset) | (paddr == psl_pkg::lamp_offset) |
                     (paddr == psl_pkg::status_offset) | (paddr == psl_pkg::mask_offset) |
                     (paddr == psl_pkg::cond_offset);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    // video streams until page done or a stop condition
    always_comb
    begin
        next_vid_state = vid_state;
        case (vid_state)
            psl_pkg::psl_vid_idle_type_v:
            begin
                if (ctrl[psl_pkg::ctrl_video_en_bit] && !stop_cause)
                begin
                    next_vid_state = psl_pkg::psl_vid_send_type_v;
                end
            end
            psl_pkg::psl_vid_send_type_v:
            begin
                if (stop_cause) // R10
                begin
                    next_vid_state = psl_pkg::psl_vid_stop_type_v;
                end
                else if (ctrl[psl_pkg::ctrl_page_done_bit] || !ctrl[psl_pkg::ctrl_video_en_bit]) // R10
                begin
                    next_vid_state = psl_pkg::psl_vid_idle_type_v;
                end
            end
            psl_pkg::psl_vid_stop_type_v:
            begin
                // stay stopped until software drops the enable
                if (!ctrl[psl_pkg::ctrl_video_en_bit])
                begin
                    next_vid_state = psl_pkg::psl_vid_idle_type_v;
                end
            end
            default: next_vid_state = psl_pkg::psl_vid_idle_type_v;
        endcase
        next_video_out = (vid_state == psl_pkg::psl_vid_send_type_v) & ~stop_cause & video_bit; // R10
    end

    // rising edges of faults and the stop become events
    always_comb
    begin
        events = '0;
        events[psl_pkg::ev_jam_bit] = cond.paper_jam & ~prev_jam;
        events[psl_pkg::ev_error_bit] = cond.error & ~prev_err;
        events[psl_pkg::ev_paper_bit] = cond.paper_out & ~prev_paper;
        events[psl_pkg::ev_stop_bit] = (vid_state == psl_pkg::psl_vid_send_type_v) & stop_cause;
        events[psl_pkg::ev_resp_bit] = status_strobe_s2 & ~status_strobe_s3; // R11
    end

    // bus decode; an event beats a write-one clear in the same cycle
    always_comb
    begin
        next_ctrl = ctrl;
        next_mask = mask;
        next_status = status;
        next_cmd_valid = 1'b0;
        next_cmd_data = cmd_data;
        next_engine_stat = (status_strobe_s2 & ~status_strobe_s3) ? status_s2 : engine_stat; // R11
        // page done is a one-shot request
        next_ctrl[psl_pkg::ctrl_page_done_bit] = 1'b0;
        next_ctrl[psl_pkg::ctrl_cmd_go_bit] = 1'b0;
        if (wr_en)
        begin
            case (paddr)
                psl_pkg::ctrl_offset:
                begin
                    next_ctrl = pwdata;
                    next_cmd_data = pwdata[15:8];
                    next_cmd_valid = pwdata[psl_pkg::ctrl_cmd_go_bit]; // R11
                end
                psl_pkg::status_offset: next_status = status & ~pwdata[psl_pkg::ev_width-1:0];
                psl_pkg::mask_offset: next_mask = pwdata[psl_pkg::ev_width-1:0];
                default: next_mask = mask;
            endcase
        end
        next_status = next_status | events;
    end

    // with pready tied high the read comes combinationally from state
    always_comb
    begin
        prdata_comb = 32'h0000_0000;
        case (paddr)
            psl_pkg::ctrl_offset: prdata_comb = {ctrl[31:3], 1'b0, ctrl[1:0]};
            psl_pkg::lamp_offset: prdata_comb = {20'h00000, engine_stat, lamps};
            psl_pkg::status_offset: prdata_comb = {27'h0000000, status};
            psl_pkg::mask_offset: prdata_comb = {27'h0000000, mask};
            psl_pkg::cond_offset: prdata_comb = {21'h000000, cond_clean};
            default: prdata_comb = 32'h0000_0000;
        endcase
    end

    assign prdata = prdata_comb;

    // status strobe from engine arrives from outside: synchronise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_strobe_s1 <= 1'b0;
            status_strobe_s2 <= 1'b0;
            status_strobe_s3 <= 1'b0;
            status_s1 <= 8'h00;
            status_s2 <= 8'h00;
        end
        else
        begin
            status_strobe_s1 <= engine_status_valid;
            status_strobe_s2 <= status_strobe_s1;
            status_strobe_s3 <= status_strobe_s2;
            status_s1 <= engine_status;
            status_s2 <= status_s1;
        end
    end

    // register and video state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= psl_pkg::ctrl_reset;
            mask <= psl_pkg::mask_reset[psl_pkg::ev_width-1:0];
            status <= '0;
            cmd_valid <= 1'b0;
            cmd_data <= 8'h00;
            engine_stat <= 8'h00;
            vid_state <= psl_pkg::psl_vid_idle_type_v;
            video_out <= 1'b0;
            prev_jam <= 1'b0;
            prev_err <= 1'b0;
            prev_paper <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            mask <= next_mask;
            status <= next_status;
            cmd_valid <= next_cmd_valid;
            cmd_data <= next_cmd_data;
            engine_stat <= next_engine_stat;
            vid_state <= next_vid_state;
            video_out <= next_video_out;
            prev_jam <= cond.paper_jam;
            prev_err <= cond.error;
            prev_paper <= cond.paper_out;
        end
    end

    assign video_active = (vid_state == psl_pkg::psl_vid_send_type_v);
    assign irq = |(status & mask);

endmodule

// *** sim/psl_status_lamps_props.sv ***
`timescale 1ns/1ps
module psl_status_lamps_props
#(
    parameter int flash_half_cycles = psl_pkg::flash_half_cycles
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // pins
    input wire psl_pkg::psl_cond_type cond_in,
    input wire psl_pkg::psl_lamps_type lamps,
    input wire logic video_active,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_valid
);
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // eight samples cover the synchroniser plus the lamp register
    sequence s_err_held;
        cond_in.error [*8];
    endsequence
    sequence s_cmd_write;
        psel && penable && pwrite && paddr == psl_pkg::ctrl_offset && pwdata[psl_pkg::ctrl_cmd_go_bit];
    endsequence
    sequence s_cmd_pulse;
        cmd_valid && cmd_data == $past(pwdata[15:8]) ##1 !cmd_valid;
    endsequence

    chk_cmd_pulse: assert property (s_cmd_write |=> s_cmd_pulse)
        else $error("command pulse wrong");
    chk_unmapped_err: assert property (psel && penable && paddr > psl_pkg::cond_offset |-> pslverr)
        else $error("unmapped access not refused");
    chk_green_steady: assert property ((cond_in.ready && !cond_in.warmup && !cond_in.operating && !cond_in.error
        && !cond_in.cover_open) [*8] |-> lamps.ready_green) else $error("green not steady");
    chk_green_off: assert property ((cond_in.error || cond_in.cover_open) [*8] |-> !lamps.ready_green)
        else $error("green lit on fault");
    chk_toner_steady: assert property (cond_in.toner_low [*8] |-> lamps.toner_orange)
        else $error("toner lamp not steady");
    chk_toner_idle: assert property ((!cond_in.toner_low && !cond_in.cart_bad) [*8] |-> !lamps.toner_orange)
        else $error("toner lamp lit");
    chk_paper_steady: assert property ((cond_in.paper_out && !cond_in.error && !cond_in.manual_ready) [*8]
        |-> lamps.paper_red) else $error("paper lamp not steady");
    chk_jam_steady: assert property ((cond_in.paper_jam && !cond_in.error) [*8] |-> lamps.jam_red)
        else $error("jam lamp not lit");
    chk_error_flash: assert property (s_err_held |-> lamps.paper_red == lamps.jam_red ##[1:10]
        $changed(lamps.paper_red)) else $error("red lamps not flashing together");
    chk_video_stop: assert property (s_err_held |-> !video_active)
        else $error("video kept running on error");
endmodule

bind psl_status_lamps psl_status_lamps_props #(.flash_half_cycles(flash_half_cycles)) u_props (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .cond_in, .lamps, .video_active, .cmd_data, .cmd_valid);

// *** sim/psl_engine_model.sv ***
`timescale 1ns/1ps
module psl_engine_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // command in, status back
    input wire logic [7:0] cmd_data,
    input wire logic cmd_valid,
    input wire logic [7:0] resp_delay,
    output logic [7:0] engine_status,
    output logic engine_status_valid,
    output logic [7:0] last_cmd
);
    logic [7:0] held;

    initial
    begin
        engine_status = 8'h00;
        engine_status_valid = 1'b0;
        last_cmd = 8'h00;
    end

    // answer each command with its inverse after a set delay
    always @(posedge pclk)
    begin
        if (presetn && cmd_valid === 1'b1)
        begin
            held = cmd_data;
            last_cmd <= held;
            repeat (resp_delay) @(posedge pclk);
            engine_status <= ~held;
            engine_status_valid <= 1'b1;
            repeat (4) @(posedge pclk);
            engine_status_valid <= 1'b0;
            engine_status <= held; // released lines show stale garbage, not the answer
        end
    end
endmodule

// *** sim/psl_status_lamps_test.sv ***
`timescale 1ns/1ps
module psl_status_lamps_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic video_bit, video_out, video_active, cmd_valid, engine_status_valid, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] cmd_data, engine_status, resp_delay, last_cmd, cb;
    psl_pkg::psl_cond_type cond_in;
    psl_pkg::psl_lamps_type lamps;
    int fails;
    int checks_done;
    // condition word, then expected mode per lamp: 0 off, 1 on, 2 flash, 3 any
    localparam logic [18:0] lamp_cases [13] = '{19'h60080, 19'h20040, 19'h30080, 19'h24000, 19'h220d0,
        19'h210e0, 19'h230d0, 19'h208c4, 19'h204c4, 19'h202c8, 19'h201c1, 19'h20040, 19'h2890a};

    psl_status_lamps #(.flash_half_cycles(8)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cond_in, .lamps, .video_bit, .video_out, .video_active, .cmd_data,
        .cmd_valid, .engine_status, .engine_status_valid, .irq);
    psl_engine_model model (.pclk, .presetn, .cmd_data, .cmd_valid, .resp_delay, .engine_status,
        .engine_status_valid, .last_cmd);

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, holding everything until pready is seen
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // classify each lamp as off, on or flashing over 20 cycles
    task automatic lamp_case(input logic [18:0] entry);
        int ones [4];
        int flips [4];
        logic [3:0] prev;
        logic [1:0] got;
        cond_in <= entry[18:8];
        repeat (10) @(posedge pclk);
        prev = lamps;
        foreach (ones[i])
        begin
            ones[i] = 0;
            flips[i] = 0;
        end
        repeat (20)
        begin
            @(posedge pclk);
            foreach (ones[i])
            begin
                ones[i] += int'(lamps[i]);
                flips[i] += int'(lamps[i] != prev[i]);
            end
            prev = lamps;
        end
        foreach (ones[i])
        begin
            got = (flips[i] > 0) ? 2'b10 : ((ones[i] == 20) ? 2'b01 : 2'b00);
            if (entry[2*i +: 2] != 2'b11)
                check_word({30'h0, got}, {30'h0, entry[2*i +: 2]});
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cond_in = 11'h000;
        video_bit = 1'b0;
        resp_delay = 8'h01;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values and a refused address
        apb_xfer(1'b0, psl_pkg::ctrl_offset, 32'h0);
        check_word(rd, psl_pkg::ctrl_reset);
        apb_xfer(1'b0, psl_pkg::mask_offset, 32'h0);
        check_word(rd, psl_pkg::mask_reset);
        apb_xfer(1'b0, 12'h020, 32'h0);
        check_word({rd[30:0], err}, 32'h1);
        $display("test registers done");
        foreach (lamp_cases[n])
            lamp_case(lamp_cases[n]);
        $display("test lamps done");
        // a fresh jam edge is needed, so drop the jam first
        cond_in <= 11'h200;
        repeat (8) @(posedge pclk);
        apb_xfer(1'b1, psl_pkg::status_offset, 32'h1f);
        apb_xfer(1'b1, psl_pkg::mask_offset, 32'h1);
        cond_in <= 11'h201;
        repeat (8) @(posedge pclk);
        check_word({31'h0, irq}, 32'h1);
        apb_xfer(1'b1, psl_pkg::mask_offset, 32'h0);
        check_word({31'h0, irq}, 32'h0);
        apb_xfer(1'b1, psl_pkg::status_offset, 32'h1);
        apb_xfer(1'b0, psl_pkg::status_offset, 32'h0);
        check_word(rd & 32'h1, 32'h0);
        $display("test interrupt done");
        // video stops on paper-out and stays stopped until enable drops
        cond_in <= 11'h200;
        apb_xfer(1'b1, psl_pkg::ctrl_offset, 32'h1);
        video_bit <= 1'b1;
        repeat (8) @(posedge pclk);
        check_word({30'h0, video_active, video_out}, 32'h3);
        cond_in <= 11'h208;
        repeat (8) @(posedge pclk);
        check_word({30'h0, video_active, video_out}, 32'h0);
        apb_xfer(1'b0, psl_pkg::status_offset, 32'h0);
        check_word(rd & 32'hc, 32'hc);
        cond_in <= 11'h200;
        repeat (8) @(posedge pclk);
        check_word({31'h0, video_active}, 32'h0);
        apb_xfer(1'b1, psl_pkg::ctrl_offset, 32'h0);
        apb_xfer(1'b1, psl_pkg::ctrl_offset, 32'h1);
        repeat (2) @(posedge pclk);
        check_word({31'h0, video_active}, 32'h1);
        cond_in <= 11'h280;
        repeat (8) @(posedge pclk);
        check_word({30'h0, video_active, video_out}, 32'h0);
        cond_in <= 11'h200;
        $display("test video done");
        // commands answered promptly, then slowly
        for (int k = 0; k < 2; k++)
        begin
            cb = 8'ha5 + 8'(k);
            resp_delay <= (k == 0) ? 8'h01 : 8'h0c;
            apb_xfer(1'b1, psl_pkg::ctrl_offset, {16'h0, cb, 8'h04});
            repeat (30) @(posedge pclk);
            check_word({24'h0, last_cmd}, {24'h0, cb});
            apb_xfer(1'b0, psl_pkg::lamp_offset, 32'h0);
            check_word({24'h0, rd[11:4]}, {24'h0, ~cb});
            apb_xfer(1'b0, psl_pkg::status_offset, 32'h0);
            check_word(rd & 32'h10, 32'h10);
            apb_xfer(1'b1, psl_pkg::status_offset, 32'h10);
        end
        $display("test command done");
        complete_run;
    end

    // whole sequence needs under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        complete_run;
    end
endmodule
